// ==== msp_pkg.sv ====
package msp_pkg;
  // register map
  localparam logic [6:0] CFG_ADDR     = 7'h40;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam int         CFG_PD_BIT   = 6;
  // clock and timing
  localparam int         MCLK_HZ      = 10_000_000;
  localparam int         TIMEOUT_MS   = 90;
  localparam int         TIMEOUT_CYC  = MCLK_HZ / 1000 * TIMEOUT_MS;
  localparam int         LED_PULSE_NS = 100_000;
  localparam int         LED_PER_CYC  = LED_PULSE_NS / 100;
  // wake-up figures and transfer length
  localparam int         WAKE_US      = 610;
  localparam int         WAKE_PD_MS   = 50;
  localparam int         WAKE_POR_MS  = 40;
  localparam int         WAKE_PD_CYC  = MCLK_HZ / 1000 * WAKE_PD_MS;
  localparam int         WAKE_POR_CYC = MCLK_HZ / 1000 * WAKE_POR_MS;
  localparam int         BITS_PER_TX  = 16;
endpackage

// ==== msp_link_if.sv ====
`timescale 1ns/100ps
// sampled serial events between the edge finder and the shifter
interface msp_link_if;
  logic rise;    // one-cycle pulse on clock rising edge
  logic fall;    // one-cycle pulse on clock falling edge
  logic dataIn;  // synchronised data line level
  modport src (output rise, output fall, output dataIn);
  modport dst (input rise, input fall, input dataIn);
endinterface

// ==== msp_edge_sync.sv ====
`timescale 1ns/100ps
// two-flop synchronisers and edge finder for the host clock and data
module msp_edge_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pins
  input  wire logic sclkPin,
  input  wire logic sdioIn,
  // events
  msp_link_if.src   lnk
);
  typedef struct packed {
    logic [1:0] clkMeta;  // first flops, read only by the second
    logic [1:0] clkSync;  // second flops
    logic       clkLast;  // previous synchronised level
    logic       rise;
    logic       fall;
    logic       dataIn;
  } msp_sync_t;
  msp_sync_t s, next_s;

  // edges come from synchronised samples only
  always_comb begin
    next_s         = s;
    next_s.clkMeta = {sdioIn, sclkPin};
    next_s.clkSync = s.clkMeta;
    next_s.clkLast = s.clkSync[0];
    next_s.rise    = s.clkSync[0] & ~s.clkLast;
    next_s.fall    = ~s.clkSync[0] & s.clkLast;
    next_s.dataIn  = s.clkSync[1];
  end

  // idle clock is high, so reset to high avoids a false edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '{clkMeta: 2'h1, clkSync: 2'h1, clkLast: 1'b1, default: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign lnk.rise   = s.rise;
  assign lnk.fall   = s.fall;
  assign lnk.dataIn = s.dataIn;
endmodule

// ==== msp_led_drive.sv ====
`timescale 1ns/100ps
// led drive: steady while moving, pulsed while idle, off in shutdown
module msp_led_drive (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // control
  input  wire logic motion,
  input  wire logic shutdown,
  // led
  output logic      ledOut,
  output logic      ledOe
);
  typedef struct packed {
    logic [15:0] cnt;  // pulse period counter
    logic        out;
    logic        oe;
  } msp_led_t;
  msp_led_t s, next_s;

  // a short flash once per period saves current when idle
  always_comb begin
    next_s     = s;
    next_s.cnt = (s.cnt == 16'(msp_pkg::LED_PER_CYC - 1)) ? 16'h0000
                 : s.cnt + 16'h0001;
    next_s.oe  = ~shutdown;
    if (motion) begin
      next_s.out = 1'b1;
    end else begin
      next_s.out = (s.cnt < 16'h0010);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ledOut = s.out;
  assign ledOe  = s.oe;
endmodule

// ==== mouse_sensor_serial_port.sv ====
`timescale 1ns/100ps
module mouse_sensor_serial_port #(
  parameter int TIMEOUT_CYCLES  = msp_pkg::TIMEOUT_CYC,
  parameter int WAKE_PD_CYCLES  = msp_pkg::WAKE_PD_CYC,
  parameter int WAKE_POR_CYCLES = msp_pkg::WAKE_POR_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // serial pins
  input  wire logic sclkPin,
  input  wire logic sdioIn,
  output logic      sdioOut,
  output logic      sdioOe,
  // sensor core
  input  wire logic motion,
  output logic      ledDriveOut,
  output logic      ledDriveOe,
  output logic      shutdownState,
  output logic      reportsValid
);
  typedef enum {ST_ADDR, ST_WDATA, ST_RDATA, ST_HOLD} msp_state_t;

  typedef struct packed {
    msp_state_t  st;
    logic [3:0]  bitCnt;     // bits taken in the current byte
    logic [7:0]  shift;      // incoming shift register
    logic [6:0]  addr;       // captured register address
    logic [7:0]  outSr;      // outgoing read data
    logic        sdo;        // data line value
    logic        oe;         // data line enable
    logic        busy;       // a transaction is open
    logic [31:0] txTimer;    // time since first edge of transaction
    logic [7:0]  cfg;        // configuration register
    logic [31:0] wakeCnt;    // time until reports are trusted
    logic        valid;
  } msp_core_t;
  msp_core_t s, next_s;

  msp_link_if lnk ();

  // address decode shared by read and write paths
  function automatic logic isCfg(input logic [6:0] a);
    isCfg = (a == msp_pkg::CFG_ADDR);
  endfunction

  msp_edge_sync u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .sclkPin (sclkPin),
    .sdioIn  (sdioIn),
    .lnk     (lnk.src)
  );

  // fed the next value, so the led lets go in the cycle the line does
  msp_led_drive u_led (
    .mclk     (mclk),
    .rst      (rst),
    .motion   (motion),
    .shutdown (next_s.cfg[msp_pkg::CFG_PD_BIT]),
    .ledOut   (ledDriveOut),
    .ledOe    (ledDriveOe)
  );

  logic pd;
  assign pd = s.cfg[msp_pkg::CFG_PD_BIT];

  // a transfer that outlives the timer is dropped, not finished
  logic timeUp;
  assign timeUp = s.busy && !pd && (s.txTimer >= 32'(TIMEOUT_CYCLES - 1));

  // serial state machine; host clock edges and the transaction timeout move it
  always_comb begin
    next_s = s;
    // wake-up timer counts down toward trusted reports
    if (s.wakeCnt != 32'h0) begin
      next_s.wakeCnt = s.wakeCnt - 32'h1;
    end else if (!pd) begin
      next_s.valid = 1'b1;
    end
    if (pd) begin
      next_s.valid = 1'b0;
    end
    // timeout runs only while awake and a transaction is open
    if (s.busy && !pd) begin
      next_s.txTimer = s.txTimer + 32'h1;
    end
    if (s.busy && !pd &&
        s.txTimer >= 32'(TIMEOUT_CYCLES - 1)) begin
      next_s.st     = ST_ADDR;
      next_s.bitCnt = 4'h0;
      next_s.busy   = 1'b0;
      next_s.oe     = 1'b0;
      next_s.txTimer = 32'h0;
    end else if (lnk.fall) begin
      next_s.busy = 1'b1;
      unique case (s.st)
        ST_RDATA: begin
          // shift the next data bit out after falling edge
          next_s.oe  = 1'b1;
          next_s.sdo = s.outSr[7];
          next_s.outSr = {s.outSr[6:0], 1'b0};
        end
        ST_HOLD: begin
          // last bit held until this falling edge
          next_s.oe   = 1'b0;
          next_s.st   = ST_ADDR;
          next_s.busy = 1'b1;
          next_s.txTimer = 32'h0;
        end
        default: begin
          next_s.oe = 1'b0;
        end
      endcase
    end else if (lnk.rise) begin
      next_s.busy  = 1'b1;
      next_s.shift = {s.shift[6:0], lnk.dataIn};
      next_s.bitCnt = s.bitCnt + 4'h1;
      unique case (s.st)
        ST_ADDR: begin
          if (s.bitCnt == 4'h7) begin
            next_s.addr   = {s.shift[5:0], lnk.dataIn};
            next_s.bitCnt = 4'h0;
            if (s.shift[6]) begin
              next_s.st = ST_WDATA;
            end else begin
              // unused addresses read as zero
              next_s.st    = ST_RDATA;
              next_s.outSr = isCfg({s.shift[5:0], lnk.dataIn})
                             ? s.cfg : 8'h00;
            end
          end
        end
        ST_WDATA: begin
          if (s.bitCnt == 4'h7) begin
            next_s.bitCnt  = 4'h0;
            next_s.st      = ST_ADDR;
            next_s.busy    = 1'b0;
            next_s.txTimer = 32'h0;
            next_s.oe      = 1'b0;
            if (isCfg(s.addr)) begin
              if (pd) begin
                // only the shutdown bit lands while asleep
                next_s.cfg[msp_pkg::CFG_PD_BIT] =
                  s.shift[5];
              end else begin
                next_s.cfg = {s.shift[6:0], lnk.dataIn};
              end
              if (pd && !s.shift[5]) begin
                next_s.wakeCnt = 32'(WAKE_PD_CYCLES);
              end
            end
          end
        end
        ST_RDATA: begin
          // host samples; last bit enters hold
          if (s.bitCnt == 4'h7) begin
            next_s.bitCnt  = 4'h0;
            next_s.st      = ST_HOLD;
            next_s.busy    = 1'b0;
            next_s.txTimer = 32'h0;
          end
        end
        ST_HOLD: begin
          // a rise here is a new address bit; release line
          next_s.st     = ST_ADDR;
          next_s.oe     = 1'b0;
          next_s.bitCnt = 4'h1;
        end
      endcase
    end
    // shutdown forces the data line released
    if (next_s.cfg[msp_pkg::CFG_PD_BIT]) begin
      next_s.oe = 1'b0;
    end
  end

  // configuration kept through shutdown; only reset clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      s         <= '0;
      s.st      <= ST_ADDR;
      s.cfg     <= msp_pkg::CFG_RESET;
      s.wakeCnt <= 32'(WAKE_POR_CYCLES);
    end else begin
      s <= next_s;
    end
  end

  assign sdioOut       = s.sdo;
  assign sdioOe        = s.oe;
  assign shutdownState = pd;
  assign reportsValid  = s.valid;

  // the sensor never drives outside a read data phase
  a_drive_only_read: assert property (
    @(posedge mclk) disable iff (rst)
    s.oe |-> (s.st == ST_RDATA || s.st == ST_HOLD))
    else $error("data driven outside read");

  // led and data line both let go while asleep
  a_no_drive_pd: assert property (
    @(posedge mclk) disable iff (rst)
    pd |-> !s.oe && !ledDriveOe)
    else $error("drive while shut down");

  // a finished write leaves the line to the host
  a_write_release: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_WDATA && lnk.rise && s.bitCnt == 4'h7) |=> !s.oe)
    else $error("write did not release line");

  // the last data bit stays until the next host falling edge
  a_hold_last: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_HOLD && !lnk.fall && !lnk.rise && !pd) |=> s.oe)
    else $error("last bit not held");

  // that falling edge ends the drive
  a_release_fall: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_HOLD && lnk.fall) |=> !s.oe)
    else $error("line not released after hold");

  // setting bit 6 puts the sensor to sleep; a timed-out write does not
  a_sd_enter: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_WDATA && lnk.rise && s.bitCnt == 4'h7 && isCfg(s.addr)
     && s.shift[5] && !timeUp) |=> pd)
    else $error("shutdown not entered");

  // clearing bit 6 while asleep wakes it
  a_sd_leave: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_WDATA && lnk.rise && s.bitCnt == 4'h7 && isCfg(s.addr)
     && pd && !s.shift[5]) |=> !pd)
    else $error("shutdown not left");

  // while asleep every bit but bit 6 keeps its value
  a_pd_keep_cfg: assert property (
    @(posedge mclk) disable iff (rst)
    (pd && $past(pd)) |-> (s.cfg[5:0] == $past(s.cfg[5:0]) &&
                           s.cfg[7] == $past(s.cfg[7])))
    else $error("config changed while asleep");

  // an awake write to the configuration register lands; bits 7 to 1 are compared
  a_cfg_write: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_WDATA && lnk.rise && s.bitCnt == 4'h7 && isCfg(s.addr)
     && !pd && !timeUp) |=> s.cfg[7:1] == $past(s.shift[6:0]))
    else $error("config write lost");

  // writes elsewhere leave the register alone
  a_unused_write: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_WDATA && lnk.rise && s.bitCnt == 4'h7 && !isCfg(s.addr))
    |=> $stable(s.cfg))
    else $error("unused write changed config");

  // a stalled transfer is thrown away after the timer runs out
  a_timeout_reset: assert property (
    @(posedge mclk) disable iff (rst)
    (s.busy && !pd && s.txTimer == 32'(TIMEOUT_CYCLES - 1)) |=>
    (s.st == ST_ADDR && s.bitCnt == 4'h0))
    else $error("timeout did not reset port");

  // the timer only holds time while a transfer is open
  a_timer_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !s.busy |-> s.txTimer == 32'h0)
    else $error("timer running while idle");

  // asleep the timer stands still, so a half command would hang the port
  a_pd_no_timer: assert property (
    @(posedge mclk) disable iff (rst)
    (pd && s.busy) |=>
    (s.txTimer == $past(s.txTimer) || s.txTimer == 32'h0))
    else $error("timer ran while asleep");

  // each read data bit goes out after a falling edge
  a_read_drive: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_RDATA && lnk.fall && !pd && !timeUp) |=> s.oe)
    else $error("read data not driven");

  // and the bits leave most significant first
  a_read_msb: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_RDATA && lnk.fall && !timeUp) |=>
    s.sdo == $past(s.outSr[7]))
    else $error("read bit out of order");

  // unused addresses read back as zero
  a_unused_zero: assert property (
    @(posedge mclk) disable iff (rst)
    (s.st == ST_ADDR && lnk.rise && s.bitCnt == 4'h7 && !s.shift[6]
     && !isCfg({s.shift[5:0], lnk.dataIn}) && !timeUp)
    |=> s.outSr == 8'h00)
    else $error("unused read not zero");

  // sleep withdraws the motion reports
  a_pd_invalid: assert property (
    @(posedge mclk) disable iff (rst)
    pd |=> !s.valid)
    else $error("reports valid while asleep");

  // awake with the wake timer spent, reports are trusted
  a_wake_valid: assert property (
    @(posedge mclk) disable iff (rst)
    (s.wakeCnt == 32'h0 && !pd) |=> s.valid)
    else $error("reports not valid after wake");

  // moving keeps the led lit on the next cycle
  a_led_steady: assert property (
    @(posedge mclk) disable iff (rst)
    motion |=> ledDriveOut)
    else $error("led not steady while moving");
endmodule

// ==== msp_host_model.sv ====
`timescale 1ns/100ps
// host master: makes the serial clock and its half of the data line
module msp_host_model (
  // serial pins
  output logic      sclk,
  output logic      lineLvl,
  // sensor side of the data line
  input  wire logic sensData,
  input  wire logic sensOe
);
  logic hostD;   // host data level
  logic hostOe;  // high while host drives the line
  logic lastLvl; // last driven level
  initial begin
    sclk = 1'b1;
    hostD = 1'b1;
    hostOe = 1'b1;
    lastLvl = 1'b1;
  end
  // released line shows the inverse of its last level, never a safe value
  always_comb begin
    if (hostOe) lineLvl = hostD;
    else if (sensOe) lineLvl = sensData;
    else lineLvl = ~lastLvl;
  end
  // remember what was last driven
  always @(hostD, hostOe, sensData, sensOe) begin
    if (hostOe | sensOe) lastLvl = hostOe ? hostD : sensData;
  end
  // host starts every transfer, data moves after the falling edge
  task automatic bitOut(input logic b);
    sclk = 1'b0;
    #100;
    hostOe = 1'b1;
    hostD = b;
    #300;
    sclk = 1'b1;
    #400;
  endtask
  // most significant bit first
  task automatic sendByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bitOut(v[i]);
  endtask
  // write, then the spacing a following command needs
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sendByte({1'b1, a});
    sendByte(d);
    #100000;
  endtask
  // read: release, wait for the sensor, clock in its byte
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    sendByte({1'b0, a});
    hostOe = 1'b0;
    #100000;
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      #400;
      sclk = 1'b1;
      d[i] = lineLvl;
      #400;
    end
  endtask
endmodule

// ==== mouse_sensor_serial_port_tb.sv ====
`timescale 1ns/100ps
// bench: register access, unused space, shutdown, timeout, led modes
module mouse_sensor_serial_port_tb;
  logic       mclk;          // system clock
  logic       rst;           // synchronous reset
  logic       sclkPin;       // host serial clock
  logic       sdioLine;      // resolved data line
  logic       sdioOut;       // sensor data
  logic       sdioOe;        // sensor drive enable
  logic       motion;        // motion level
  logic       ledDriveOut;   // led level
  logic       ledDriveOe;    // led enable
  logic       shutdownState; // shutdown flag
  logic       reportsValid;  // reports ready
  logic [7:0] rdData;        // read result
  int         nMismatch;     // mismatches
  int         nTests;        // comparisons
  int         cnt;           // led high cycles
  // long counts shortened so the run stays brief
  mouse_sensor_serial_port #(.TIMEOUT_CYCLES(2000), .WAKE_PD_CYCLES(500),
    .WAKE_POR_CYCLES(400)) i_mouse_sensor_serial_port (.mclk(mclk),
    .rst(rst), .sclkPin(sclkPin), .sdioIn(sdioLine), .sdioOut(sdioOut),
    .sdioOe(sdioOe), .motion(motion), .ledDriveOut(ledDriveOut),
    .ledDriveOe(ledDriveOe), .shutdownState(shutdownState),
    .reportsValid(reportsValid));
  msp_host_model i_msp_host_model (.sclk(sclkPin), .lineLvl(sdioLine),
    .sensData(sdioOut), .sensOe(sdioOe));
  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // inputs move a fixed step after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (nMismatch == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // reset state, power-up wait, read of the reset value
  task automatic tReset();
    check("valid early", {7'h0, reportsValid}, 8'h00);
    cyc(410);
    check("valid late", {7'h0, reportsValid}, 8'h01);
    i_msp_host_model.rd(7'h40, rdData);
    check("cfg reset", rdData, 8'h00);
  endtask
  // write then read back; last bit held until the next falling edge
  task automatic tRegRw();
    i_msp_host_model.wr(7'h40, 8'h15);
    i_msp_host_model.rd(7'h40, rdData);
    check("cfg rw", rdData, 8'h15);
    check("hold oe", {7'h0, sdioOe}, 8'h01);
  endtask
  // unused address: write releases, changes nothing, reads zero
  task automatic tUnused();
    i_msp_host_model.wr(7'h77, 8'hff);
    check("oe unused", {7'h0, sdioOe}, 8'h00);
    i_msp_host_model.rd(7'h77, rdData);
    check("rd unused", rdData, 8'h00);
    i_msp_host_model.rd(7'h40, rdData);
    check("cfg kept", rdData, 8'h15);
  endtask
  // shutdown entry, only bit 6 taken while asleep, wake and settings kept
  task automatic tShutdown();
    i_msp_host_model.wr(7'h40, 8'h55);
    check("pd on", {7'h0, shutdownState}, 8'h01);
    check("led oe pd", {7'h0, ledDriveOe}, 8'h00);
    check("oe pd", {7'h0, sdioOe}, 8'h00);
    check("valid pd", {7'h0, reportsValid}, 8'h00);
    i_msp_host_model.wr(7'h40, 8'h7f);
    i_msp_host_model.wr(7'h40, 8'h0a);
    check("pd off", {7'h0, shutdownState}, 8'h00);
    check("oe wake", {7'h0, sdioOe}, 8'h00);
    check("valid wake", {7'h0, reportsValid}, 8'h01);
    check("led oe wake", {7'h0, ledDriveOe}, 8'h01);
    i_msp_host_model.rd(7'h40, rdData);
    check("cfg asleep", rdData, 8'h15);
  endtask
  // partial command is dropped after the transaction timeout
  task automatic tTimeout();
    repeat (5) i_msp_host_model.bitOut(1'b1);
    cyc(2100);
    i_msp_host_model.rd(7'h40, rdData);
    check("after timeout", rdData, 8'h15);
  endtask
  // led steady while moving, 16 of every 1000 cycles while idle
  task automatic tLed();
    motion = 1'b1;
    cyc(20);
    cnt = 0;
    repeat (100) begin
      cyc(1);
      cnt += int'(ledDriveOut === 1'b1);
    end
    check("led moving", 8'(cnt), 8'd100);
    motion = 1'b0;
    cyc(20);
    cnt = 0;
    repeat (1000) begin
      cyc(1);
      cnt += int'(ledDriveOut === 1'b1);
    end
    check("led idle", 8'(cnt), 8'd16);
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    motion = 1'b0;
    nMismatch = 0;
    nTests = 0;
    cyc(6);
    rst = 1'b0;
    cyc(3);
    tReset();
    tRegRw();
    tUnused();
    tShutdown();
    tTimeout();
    tLed();
    conclude();
  end
  // watchdog: about two and a half times the expected run
  initial begin
    #4000000;
    nMismatch++;
    conclude();
  end
endmodule
